// ===== src/sram_ctrl.sv
// host-side controller for an 8k by 8 asynchronous static memory
// assumes user request inputs synchronous to clk; pins resolved outside
// Contract
// - controller spaces writes by one write cycle time
// - selects held asserted 70 or 80 ns before write end
// - address valid 70 or 80 ns before write end
// - address stable no later than strobe fall
// - write strobe held low at least 60 ns
// - address unchanged until write ends
// - write data valid 40 ns before write end, held to end
// - controller never drives data while device drives it
// - deselect before retention and keep deselected throughout
`timescale 1ns/10ps
module sram_ctrl (
    input wire logic clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic enable, // clock enable, freezes state when low
    input wire logic slow_grade, // 1 selects the 100 ns limit set
    input wire logic retain, // hold device deselected for retention
    input wire logic req, // access request, one cycle
    input wire logic req_write, // 1 write, 0 read
    input wire logic [sram_ctrl_pkg::addr_w-1:0] req_address, // word address
    input wire logic [sram_ctrl_pkg::data_w-1:0] req_wdata, // write data
    output logic busy, // request would be refused
    output logic rd_valid, // read data pulse
    output logic [sram_ctrl_pkg::data_w-1:0] rd_data, // read data
    output logic [sram_ctrl_pkg::addr_w-1:0] word_address, // memory address pins
    output logic select_low_n, // chip select, active low
    output logic select_high, // chip select, active high
    output logic write_n, // write strobe, active low
    output logic gate_n, // output gate, active low
    input wire logic [sram_ctrl_pkg::data_w-1:0] data_lines_in, // data pins in
    output logic [sram_ctrl_pkg::data_w-1:0] data_lines_out, // data pins out
    output logic data_lines_oe // drive enable for data pins
);
    typedef enum logic [2:0] {idle, rd_access, rd_float, wr_strobe, wr_recover, hold_off}
        state_e;

    localparam logic [sram_ctrl_pkg::cnt_w-1:0] rc_f =
        sram_ctrl_pkg::cnt_w'(sram_ctrl_pkg::rc_fast_cyc);
    localparam logic [sram_ctrl_pkg::cnt_w-1:0] rc_s =
        sram_ctrl_pkg::cnt_w'(sram_ctrl_pkg::rc_slow_cyc);
    localparam logic [sram_ctrl_pkg::cnt_w-1:0] wc_f =
        sram_ctrl_pkg::cnt_w'(sram_ctrl_pkg::wc_fast_cyc);
    localparam logic [sram_ctrl_pkg::cnt_w-1:0] wc_s =
        sram_ctrl_pkg::cnt_w'(sram_ctrl_pkg::wc_slow_cyc);
    localparam logic [sram_ctrl_pkg::cnt_w-1:0] cw_f =
        sram_ctrl_pkg::cnt_w'(sram_ctrl_pkg::cw_fast_cyc);
    localparam logic [sram_ctrl_pkg::cnt_w-1:0] cw_s =
        sram_ctrl_pkg::cnt_w'(sram_ctrl_pkg::cw_slow_cyc);
    localparam logic [sram_ctrl_pkg::cnt_w-1:0] hz_c =
        sram_ctrl_pkg::cnt_w'(sram_ctrl_pkg::hz_cyc);
    localparam logic [sram_ctrl_pkg::cnt_w-1:0] ow_c =
        sram_ctrl_pkg::cnt_w'(sram_ctrl_pkg::ow_cyc);

    state_e state;
    state_e next_state;
    logic [sram_ctrl_pkg::data_w-1:0] next_rd_data;
    logic [sram_ctrl_pkg::addr_w-1:0] next_word_address;
    logic [sram_ctrl_pkg::data_w-1:0] next_data_lines_out;
    logic next_select, next_write_n, next_gate_n, next_oe, next_rd_valid, next_busy;
    logic was_retain, next_was_retain;
    logic t_load, t_done, s_load, s_done;
    logic [sram_ctrl_pkg::cnt_w-1:0] t_value, s_value;
    logic [sram_ctrl_pkg::cnt_w-1:0] rc_c, wc_c, cw_c, phase_c;

    // one grade input picks the read, write and select limits at once; float and recovery are fixed
    assign rc_c = slow_grade ? rc_s : rc_f;
    assign wc_c = slow_grade ? wc_s : wc_f;
    assign cw_c = slow_grade ? cw_s : cw_f;
    // strobe phase covers the longer of pulse width and select-to-end
    assign phase_c = cw_c;

    // phase timer: access, strobe, float waits
    cycle_timer phase_timer (
        .clk(clk),
        .reset(reset),
        .enable(enable),
        .load(t_load),
        .value(t_value),
        .done(t_done)
    );

    // spacing timer: full read or write cycle from start
    cycle_timer space_timer (
        .clk(clk),
        .reset(reset),
        .enable(enable),
        .load(s_load),
        .value(s_value),
        .done(s_done)
    );

    always_comb begin
        next_state = state;
        next_rd_data = rd_data;
        next_word_address = word_address;
        next_data_lines_out = data_lines_out;
        next_select = ~select_low_n;
        next_write_n = write_n;
        next_gate_n = gate_n;
        next_oe = data_lines_oe;
        next_rd_valid = 1'b0;
        next_was_retain = was_retain;
        t_load = 1'b0;
        t_value = '0;
        s_load = 1'b0;
        s_value = '0;
        case (state)
            idle: begin
                if (retain) begin
                    next_select = 1'b0;
                    next_was_retain = 1'b1;
                end else if (was_retain) begin
                    next_was_retain = 1'b0;
                    next_state = hold_off;
                    t_load = 1'b1;
                    t_value = rc_c;
                end else if (req && s_done) begin
                    next_word_address = req_address;
                    next_select = 1'b1;
                    s_load = 1'b1;
                    t_load = 1'b1;
                    if (req_write) begin
                        next_write_n = 1'b0;
                        next_gate_n = 1'b1;
                        next_data_lines_out = req_wdata;
                        next_oe = 1'b1;
                        s_value = wc_c;
                        t_value = phase_c;
                        next_state = wr_strobe;
                    end else begin
                        next_gate_n = 1'b0;
                        next_oe = 1'b0;
                        s_value = rc_c;
                        t_value = rc_c;
                        next_state = rd_access;
                    end
                end
            end
            rd_access: begin
                if (t_done) begin
                    next_rd_data = data_lines_in;
                    next_rd_valid = 1'b1;
                    next_gate_n = 1'b1;
                    next_select = 1'b0;
                    t_load = 1'b1;
                    t_value = hz_c;
                    next_state = rd_float;
                end
            end
            rd_float: begin
                if (t_done) begin
                    next_state = idle;
                end
            end
            wr_strobe: begin
                // address and data held untouched to the end
                if (t_done) begin
                    next_write_n = 1'b1;
                    next_select = 1'b0;
                    t_load = 1'b1;
                    t_value = ow_c;
                    next_state = wr_recover;
                end
            end
            wr_recover: begin
                // data held past strobe rise, released before device may drive
                if (t_done) begin
                    next_oe = 1'b0;
                    next_state = idle;
                end
            end
            hold_off: begin
                next_select = 1'b0;
                if (t_done) begin
                    next_state = idle;
                end
            end
            default: begin
                next_state = idle;
            end
        endcase
        next_busy = (next_state != idle) || retain || next_was_retain;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state <= idle;
            rd_data <= '0;
            rd_valid <= 1'b0;
            word_address <= '0;
            data_lines_out <= '0;
            select_low_n <= 1'b1;
            select_high <= 1'b0;
            write_n <= 1'b1;
            gate_n <= 1'b1;
            data_lines_oe <= 1'b0;
            was_retain <= 1'b0;
            busy <= 1'b1;
        end else if (enable) begin
            state <= next_state;
            rd_data <= next_rd_data;
            rd_valid <= next_rd_valid;
            word_address <= next_word_address;
            data_lines_out <= next_data_lines_out;
            select_low_n <= ~next_select;
            select_high <= next_select;
            write_n <= next_write_n;
            gate_n <= next_gate_n;
            data_lines_oe <= next_oe;
            was_retain <= next_was_retain;
            busy <= next_busy;
        end
    end

    // never drive data while the device may be driving a read
    no_contention_a: assert property (@(posedge clk) disable iff (reset)
        !(data_lines_oe && !gate_n && write_n)) else $error("data driven during read");
    strobe_width_a: assert property (@(posedge clk) disable iff (reset)
        enable throughout ($fell(write_n) ##1 1'b1[*7]) |-> !write_n)
        else $error("write strobe too short");
    write_address_a: assert property (@(posedge clk) disable iff (reset)
        !write_n && $past(!write_n) |-> $stable(word_address)) else $error("address moved");
    write_data_a: assert property (@(posedge clk) disable iff (reset)
        !write_n |-> data_lines_oe) else $error("write data not driven");
    select_during_write_a: assert property (@(posedge clk) disable iff (reset)
        !write_n |-> (!select_low_n && select_high)) else $error("write without select");
    retain_deselect_a: assert property (@(posedge clk) disable iff (reset)
        $past(retain) && $past(enable) && $past(state == idle) |-> select_low_n)
        else $error("selected during retention");
    // address launched with the strobe, never one cycle behind it
    address_setup_a: assert property (@(posedge clk) disable iff (reset)
        $fell(write_n) |=> $stable(word_address))
        else $error("address late");
    read_space_a: assert property (@(posedge clk) disable iff (reset)
        enable throughout ($fell(gate_n) ##1 1'b1[*8]) |-> !gate_n)
        else $error("read cycle too short");
    selects_agree_a: assert property (@(posedge clk) disable iff (reset)
        select_high == !select_low_n) else $error("selects disagree");
    read_cover: cover property (@(posedge clk) disable iff (reset) rd_valid);
    write_cover: cover property (@(posedge clk) disable iff (reset) $rose(write_n));
    retain_cover: cover property (@(posedge clk) disable iff (reset) state == hold_off);
endmodule

// ===== src/sram_ctrl_pkg.sv
// timing and geometry constants for the static memory controller
// assumes a 125 MHz system clock
package sram_ctrl_pkg;
    localparam int addr_w = 13;
    localparam int data_w = 8;
    localparam int clk_ps = 8000;
    localparam int cnt_w = 5;
    // times in ns, fast grade then slow grade
    localparam int rc_fast_ns = 80;
    localparam int rc_slow_ns = 100;
    localparam int wc_fast_ns = 80;
    localparam int wc_slow_ns = 100;
    localparam int cw_fast_ns = 70;
    localparam int cw_slow_ns = 80;
    localparam int wp_ns = 60;
    localparam int dw_ns = 40;
    localparam int hz_ns = 30;
    localparam int ohz_ns = 20;
    localparam int ow_ns = 10;
    // least times round up
    localparam int rc_fast_cyc = (rc_fast_ns * 1000 + clk_ps - 1) / clk_ps;
    localparam int rc_slow_cyc = (rc_slow_ns * 1000 + clk_ps - 1) / clk_ps;
    localparam int wc_fast_cyc = (wc_fast_ns * 1000 + clk_ps - 1) / clk_ps;
    localparam int wc_slow_cyc = (wc_slow_ns * 1000 + clk_ps - 1) / clk_ps;
    localparam int cw_fast_cyc = (cw_fast_ns * 1000 + clk_ps - 1) / clk_ps;
    localparam int cw_slow_cyc = (cw_slow_ns * 1000 + clk_ps - 1) / clk_ps;
    localparam int wp_cyc = (wp_ns * 1000 + clk_ps - 1) / clk_ps;
    localparam int dw_cyc = (dw_ns * 1000 + clk_ps - 1) / clk_ps;
    // bus turnaround: device float time after gate or select release
    localparam int hz_cyc = (hz_ns * 1000 + clk_ps - 1) / clk_ps;
    localparam int ohz_cyc = (ohz_ns * 1000 + clk_ps - 1) / clk_ps;
    localparam int ow_cyc = (ow_ns * 1000 + clk_ps - 1) / clk_ps;
endpackage

// ===== src/cycle_timer.sv
// down counter that loads a cycle count and flags zero
// assumes load and enable in the same clock domain
`timescale 1ns/10ps
module cycle_timer (
    input wire logic clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic enable, // clock enable
    input wire logic load, // load count
    input wire logic [sram_ctrl_pkg::cnt_w-1:0] value, // count to load
    output logic done // count at zero
);
    logic [sram_ctrl_pkg::cnt_w-1:0] count;
    logic [sram_ctrl_pkg::cnt_w-1:0] next_count;

    always_comb begin
        next_count = count;
        if (load) begin
            next_count = value;
        end else if (count != '0) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count <= '0;
        end else if (enable) begin
            count <= next_count;
        end
    end

    assign done = (count == '0);
endmodule

// ===== verif/sram_model.sv
// behavioural 8k by 8 static memory with async control pins
// assumes the bench resolves the shared data pins into bus
`timescale 1ns/10ps
module sram_model (
    input wire logic slow, // 1 gives the 100 ns access grade
    input wire logic [sram_ctrl_pkg::addr_w-1:0] word_address, // address pins
    input wire logic select_low_n, // select, active low
    input wire logic select_high, // select, active high
    input wire logic write_n, // write strobe, active low
    input wire logic gate_n, // output gate, active low
    input wire logic [sram_ctrl_pkg::data_w-1:0] bus, // resolved data pins
    output logic [sram_ctrl_pkg::data_w-1:0] dev_data, // device drive value
    output logic dev_oe, // device drives the pins
    output logic fault // far side broke a write limit
);
    logic [7:0] mem [0:8191];
    logic sel;
    logic read_on;
    logic wr_on;
    realtime acc;
    realtime t_fall;
    realtime t_data;
    realtime t_addr;
    assign sel = !select_low_n && select_high;
    assign read_on = sel && write_n && !gate_n;
    assign wr_on = sel && !write_n;
    initial begin
        dev_oe = 1'b0;
        dev_data = 8'h00;
        fault = 1'b0;
    end
    // just under the maximum so a sample at the limit edge is not a race
    always @(read_on or word_address) begin
        acc = slow ? 99 : 79;
        if (!read_on) begin
            dev_oe <= #5 1'b0;
        end else begin
            dev_oe <= #10 1'b1;
            dev_data <= #10 ~dev_data;
            dev_data <= #(acc) mem[word_address];
        end
    end
    always @(bus) t_data = $realtime;
    always @(word_address) t_addr = $realtime;
    always @(posedge wr_on) t_fall = $realtime;
    // write ends at strobe rise or select release, whichever comes first
    always @(negedge wr_on) begin
        mem[word_address] <= bus;
        if ($realtime - t_fall < (slow ? 80 : 70)) fault = 1'b1;
        if ($realtime - t_addr < (slow ? 80 : 70) || t_addr > t_fall) fault = 1'b1;
        if ($realtime - t_data < 40) fault = 1'b1;
    end
endmodule

// ===== verif/test_sram_ctrl.sv
// self-checking bench for the static memory controller
// assumes sram_model on the pins; data pin level resolved here
`timescale 1ns/10ps
module test_sram_ctrl;
    logic clk, reset, enable, slow_grade, retain, req, req_write, busy, rd_valid;
    logic [sram_ctrl_pkg::addr_w-1:0] req_address, word_address;
    logic [sram_ctrl_pkg::data_w-1:0] req_wdata, rd_data, out_data, dev_data, bus, pat;
    logic select_low_n, select_high, write_n, gate_n, oe, dev_oe, fault;
    int err_count = 0;
    int n_tests = 0;
    // released pins show a changing pattern, never the last value
    assign bus = oe ? out_data : (dev_oe ? dev_data : pat);
    sram_ctrl i_sram_ctrl (.clk(clk), .reset(reset), .enable(enable), .slow_grade(slow_grade),
        .retain(retain), .req(req), .req_write(req_write), .req_address(req_address),
        .req_wdata(req_wdata), .busy(busy), .rd_valid(rd_valid), .rd_data(rd_data),
        .word_address(word_address), .select_low_n(select_low_n), .select_high(select_high),
        .write_n(write_n), .gate_n(gate_n), .data_lines_in(bus), .data_lines_out(out_data),
        .data_lines_oe(oe));
    sram_model i_sram_model (.slow(slow_grade), .word_address(word_address),
        .select_low_n(select_low_n), .select_high(select_high), .write_n(write_n),
        .gate_n(gate_n), .bus(bus), .dev_data(dev_data), .dev_oe(dev_oe), .fault(fault));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial pat = 8'h3c;
    always @(posedge clk) begin
        pat <= pat + 8'h5b;
        if (dev_oe && oe) begin
            err_count++;
            $display("ERROR pin contention expected 0 seen 1");
        end
    end
    task check(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task wait_idle;
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 100) begin
            @(negedge clk);
            k++;
        end
        check("idle", 24'h0, {23'h0, busy});
    endtask
    task send(input logic w, input logic [12:0] a, input logic [7:0] d);
        @(negedge clk);
        req = 1'b1;
        req_write = w;
        req_address = a;
        req_wdata = d;
        @(negedge clk);
        req = 1'b0;
    endtask
    task do_write(input logic [12:0] a, input logic [7:0] d);
        wait_idle;
        send(1'b1, a, d);
        @(negedge clk);
        check("write pins", {a, d, 3'b100},
            {word_address, out_data, oe, write_n, select_low_n});
    endtask
    task do_read(input logic [12:0] a, input logic [7:0] d, input logic s);
        int k;
        wait_idle;
        send(1'b0, a, 8'h00);
        k = 0;
        while (rd_valid !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        check("read latency", s ? 24'd14 : 24'd11, 24'(k));
        check("rd_data", {16'h0, d}, {16'h0, rd_data});
    endtask
    task run_grade(input logic s);
        do_write(13'h0000, 8'h5a ^ {8{s}});
        do_write(13'h1fff, 8'ha5 ^ {8{s}});
        do_read(13'h0000, 8'h5a ^ {8{s}}, s);
        do_read(13'h1fff, 8'ha5 ^ {8{s}}, s);
        do_write(13'h1234, 8'h3c ^ {8{s}});
        do_read(13'h1234, 8'h3c ^ {8{s}}, s);
    endtask
    // read with the clock enable dropped for three edges: all timing stretches
    task stall_read;
        int k;
        wait_idle;
        send(1'b0, 13'h1234, 8'h00);
        enable = 1'b0;
        repeat (3) @(negedge clk);
        check("frozen pins", {13'h1234, 3'b001}, {word_address, select_low_n, gate_n, busy});
        enable = 1'b1;
        k = 3;
        while (rd_valid !== 1'b1 && k < 40) begin
            @(negedge clk);
            k++;
        end
        check("stall latency", 24'd17, 24'(k));
        check("stall rd_data", 24'hc3, {16'h0, rd_data});
    endtask
    task refuse_write;
        wait_idle;
        send(1'b1, 13'h0100, 8'h77);
        send(1'b1, 13'h0100, 8'h88);
        do_read(13'h0100, 8'h77, 1'b1);
    endtask
    task retention;
        int k;
        do_write(13'h0042, 8'h11);
        wait_idle;
        retain = 1'b1;
        @(negedge clk);
        check("retain pins", 24'h5, {21'h0, select_low_n, select_high, busy});
        send(1'b1, 13'h0042, 8'hee);
        repeat (4) @(negedge clk);
        check("retain hold", 24'h2, {22'h0, select_low_n, select_high});
        retain = 1'b0;
        k = 0;
        while (busy !== 1'b0 && k < 50) begin
            @(negedge clk);
            k++;
        end
        check("hold off", 24'h1, 24'(k >= sram_ctrl_pkg::rc_slow_cyc));
        do_read(13'h0042, 8'h11, 1'b1);
    endtask
    initial begin
        reset = 1'b1;
        enable = 1'b1;
        slow_grade = 1'b0;
        retain = 1'b0;
        req = 1'b0;
        req_write = 1'b0;
        req_address = 13'h0000;
        req_wdata = 8'h00;
        repeat (4) @(negedge clk);
        check("reset pins", 24'he, {20'h0, select_low_n, write_n, gate_n, oe});
        reset = 1'b0;
        repeat (2) @(negedge clk);
        run_grade(1'b0);
        wait_idle;
        slow_grade = 1'b1;
        run_grade(1'b1);
        stall_read;
        refuse_write;
        retention;
        check("model fault", 24'h0, {23'h0, fault});
        report_and_stop;
    end
    initial begin
        #100000;
        err_count++;
        report_and_stop;
    end
endmodule
